// ==== hdl/akr_pkg.sv ====
// package for the remote-control key state machine
// assumes a single 200 MHz clock domain; key inputs are raw pins
package akr_pkg;
	// ***************
	// timing
	// ***************
	localparam int AKR_CLK_MHZ = 200;
	localparam int AKR_TX_US = 20;
	localparam int AKR_TX_CYC = AKR_TX_US * AKR_CLK_MHZ;
	localparam int AKR_FRAME_BITS = 40;
	// ***************
	// value ranges and resets
	// ***************
	localparam logic [4:0] AKR_TEMP_MIN = 5'h11;
	localparam logic [4:0] AKR_TEMP_MAX = 5'h1e;
	localparam logic [4:0] AKR_TEMP_RST = 5'h18;
	localparam logic [7:0] AKR_TIMER_MAX = 8'h8f;
	localparam logic [7:0] AKR_TIMER_RST = 8'h00;
	localparam logic [4:0] AKR_ANGLE_MAX = 5'h0f;
	localparam logic [4:0] AKR_ANGLE_RST = 5'h00;
	localparam logic [10:0] AKR_CLOCK_RST = 11'h2d0;
	localparam logic [10:0] AKR_CLOCK_WRAP = 11'h59f;
	// a minute of cycles overflows int, so this count is 64 bits wide
	localparam longint AKR_MIN_CYC = longint'(60) * 1000000 * AKR_CLK_MHZ;

	typedef enum logic [2:0] {
		AKR_MODE_AUTO, AKR_MODE_COOL, AKR_MODE_DRY, AKR_MODE_HEAT, AKR_MODE_FAN
	} akr_mode_t;

	typedef enum logic [1:0] {
		AKR_FAN_AUTO, AKR_FAN_LOW, AKR_FAN_MED, AKR_FAN_HIGH
	} akr_fan_t;

	// one-cycle key press strobes after debounce
	typedef struct packed {
		logic onoff;
		logic mode;
		logic fan;
		logic up;
		logic down;
		logic swing;
		logic direction;
		logic boost;
		logic sleep;
		logic reset;
		logic cancel;
		logic timer;
		logic clock;
		logic indoor_display_toggle;
		logic lock;
		logic oxygen_function;
	} akr_keys_t;

	localparam int AKR_NKEYS = 16;

	// complete setting state sent to the indoor unit
	typedef struct packed {
		logic run;
		akr_mode_t mode;
		akr_fan_t fan;
		logic [4:0] temp;
		logic swing;
		logic [4:0] angle;
		logic boost;
		logic sleep;
		logic disp_toggle;
		logic oxygen;
		logic [7:0] timer_on;
		logic [7:0] timer_off;
		// pads the setting to exactly one frame
		logic [2:0] pad;
	} akr_setting_t;

	// lcd indications
	typedef struct packed {
		logic tx_icon;
		logic run_icon;
		akr_mode_t mode;
		logic [2:0] fan_bars;
		logic temp_show;
		logic [4:0] temp;
		logic time_is_timer;
		logic [10:0] time_min;
		logic lock_icon;
		logic sleep_icon;
	} akr_lcd_t;
endpackage

// ==== hdl/akr_key_sync.sv ====
// key input conditioner: two-stage synchroniser and rising-edge pulse per key
// assumes keys are raw, active-high pins already debounced mechanically
`timescale 1ns/1ps
module akr_key_sync
	import akr_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// pins in, pulses out
	input wire logic [AKR_NKEYS-1:0] key_pin_i,
	output akr_keys_t key_press_o
);
	typedef struct packed {
		logic [AKR_NKEYS-1:0] s1;
		logic [AKR_NKEYS-1:0] s2;
		logic [AKR_NKEYS-1:0] s3;
	} akr_sync_st_t;

	akr_sync_st_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = key_pin_i;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// edge detection reads only the second stage and its delayed copy
	assign key_press_o = akr_keys_t'(st_q.s2 & ~st_q.s3);
endmodule

// ==== hdl/akr_remote.sv ====
// top of the remote-control key state machine: keys in, settings, lcd and ir frame out
// assumes raw key pins, a 200 MHz clock and a serial ir modulator fed by frame_bit_o
`timescale 1ns/1ps
module akr_remote
	import akr_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// configuration
	input wire logic cool_only_i,
	// keys, raw pins
	input wire logic [AKR_NKEYS-1:0] key_pin_i,
	// indoor unit link
	output logic frame_bit_o,
	output logic frame_active_o,
	// state and display
	output akr_setting_t setting_o,
	output akr_lcd_t lcd_o,
	output logic lock_o
);
	// ***************
	// reset release
	// ***************
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ***************
	// key pulses
	// ***************
	akr_keys_t kp;

	akr_key_sync u_keys (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.key_pin_i(key_pin_i),
		.key_press_o(kp)
	);

	// ***************
	// helpers
	// ***************
	function automatic akr_mode_t next_mode(input akr_mode_t m, input logic cool_only);
		akr_mode_t n;
		n = AKR_MODE_AUTO;
		unique case (m)
			AKR_MODE_AUTO: n = AKR_MODE_COOL;
			AKR_MODE_COOL: n = AKR_MODE_DRY;
			AKR_MODE_DRY: n = cool_only ? AKR_MODE_FAN : AKR_MODE_HEAT;
			AKR_MODE_HEAT: n = AKR_MODE_FAN;
			AKR_MODE_FAN: n = AKR_MODE_AUTO;
			default: n = AKR_MODE_AUTO;
		endcase
		return n;
	endfunction

	function automatic logic [7:0] timer_step(input logic [7:0] t, input logic up);
		logic [7:0] r;
		r = t;
		if (up) begin
			r = (t >= AKR_TIMER_MAX) ? 8'h00 : t + 8'h01;
		end else begin
			r = (t == 8'h00) ? AKR_TIMER_MAX : t - 8'h01;
		end
		return r;
	endfunction

	// ten-minute units to minutes as t*8 + t*2
	function automatic logic [10:0] ten_min(input logic [7:0] t);
		return {t, 3'h0} + {2'h0, t, 1'b0};
	endfunction

	// ***************
	// state
	// ***************
	typedef enum logic [1:0] {ED_TEMP, ED_ON, ED_OFF} akr_edit_t;
	typedef enum logic {TX_IDLE, TX_SEND} akr_tx_t;

	typedef struct packed {
		akr_setting_t set;
		akr_edit_t edit;
		logic lock;
		logic angle_down;
		logic show_clock;
		logic [10:0] clock_min;
		// a minute of cycles needs 34 bits
		logic [34:0] min_cnt;
		akr_tx_t tx;
		logic tx_pend;
		logic [AKR_FRAME_BITS-1:0] shreg;
		logic [5:0] bit_cnt;
		logic [12:0] bit_tmr;
		akr_lcd_t lcd;
	} akr_state_t;

	akr_state_t st_q, st_d;
	akr_setting_t set_rst;

	always_comb begin
		set_rst = '0;
		set_rst.mode = AKR_MODE_AUTO;
		set_rst.fan = AKR_FAN_AUTO;
		set_rst.temp = AKR_TEMP_RST;
		set_rst.angle = AKR_ANGLE_RST;
		set_rst.timer_on = AKR_TIMER_RST;
		set_rst.timer_off = AKR_TIMER_RST;
	end

	logic any_key;
	logic other_key;
	logic change;

	assign any_key = |kp;
	assign other_key = any_key & ~kp.sleep;

	// ***************
	// next state
	// ***************
	always_comb begin
		st_d = st_q;
		change = 1'b0;

		// free-running wall clock in minutes
		if (st_q.min_cnt == 35'(AKR_MIN_CYC - 1)) begin
			st_d.min_cnt = '0;
			st_d.clock_min = (st_q.clock_min == AKR_CLOCK_WRAP) ? 11'h000 :
				st_q.clock_min + 11'h001;
		end else begin
			st_d.min_cnt = st_q.min_cnt + 35'h1;
		end

		if (kp.lock) begin
			st_d.lock = ~st_q.lock;
		end else if (!st_q.lock && any_key) begin
			change = 1'b1;
			st_d.show_clock = 1'b0;
			if (st_q.set.sleep && other_key) begin
				st_d.set.sleep = 1'b0;
			end
			if (kp.reset) begin
				st_d.set = set_rst;
				st_d.edit = ED_TEMP;
				st_d.angle_down = 1'b0;
			end else begin
				if (kp.onoff) begin
					st_d.set.run = ~st_q.set.run;
				end
				if (kp.mode) begin
					st_d.set.mode = next_mode(st_q.set.mode, cool_only_i);
					st_d.set.boost = 1'b0;
				end
				if (kp.fan) begin
					st_d.set.fan = akr_fan_t'(st_q.set.fan + 2'h1);
				end
				if (kp.swing) begin
					st_d.set.swing = ~st_q.set.swing;
				end
				if (kp.direction) begin
					// step one 6 degree notch, turn round at either end
					if (st_q.angle_down) begin
						st_d.set.angle = st_q.set.angle - 5'h01;
						if (st_q.set.angle == 5'h01) begin
							st_d.angle_down = 1'b0;
						end
					end else begin
						st_d.set.angle = st_q.set.angle + 5'h01;
						if (st_q.set.angle == AKR_ANGLE_MAX - 5'h01) begin
							st_d.angle_down = 1'b1;
						end
					end
				end
				if (kp.up || kp.down) begin
					unique case (st_q.edit)
						ED_TEMP: begin
							if (kp.up && st_q.set.temp < AKR_TEMP_MAX) begin
								st_d.set.temp = st_q.set.temp + 5'h01;
							end else if (kp.down && st_q.set.temp > AKR_TEMP_MIN) begin
								st_d.set.temp = st_q.set.temp - 5'h01;
							end
						end
						ED_ON: st_d.set.timer_on =
							timer_step(st_q.set.timer_on, kp.up);
						ED_OFF: st_d.set.timer_off =
							timer_step(st_q.set.timer_off, kp.up);
						default: st_d.edit = ED_TEMP;
					endcase
				end
				if (kp.timer) begin
					unique case (st_q.edit)
						ED_TEMP: st_d.edit = ED_ON;
						ED_ON: st_d.edit = ED_OFF;
						ED_OFF: st_d.edit = ED_TEMP;
						default: st_d.edit = ED_TEMP;
					endcase
				end
				if (kp.boost && st_q.set.mode == AKR_MODE_COOL) begin
					st_d.set.boost = ~st_q.set.boost;
				end
				if (kp.sleep && (st_q.set.mode == AKR_MODE_COOL ||
					st_q.set.mode == AKR_MODE_HEAT || st_q.set.mode == AKR_MODE_AUTO)) begin
					st_d.set.sleep = ~st_q.set.sleep;
				end
				if (kp.cancel) begin
					st_d.set.timer_on = 8'h00;
					st_d.set.timer_off = 8'h00;
					st_d.edit = ED_TEMP;
				end
				if (kp.clock) begin
					st_d.show_clock = 1'b1;
				end
				if (kp.indoor_display_toggle) begin
					st_d.set.disp_toggle = ~st_q.set.disp_toggle;
				end
				if (kp.oxygen_function) begin
					st_d.set.oxygen = ~st_q.set.oxygen;
				end
			end
		end

		// auto and dry never carry a fixed fan speed
		if (st_d.set.mode == AKR_MODE_AUTO || st_d.set.mode == AKR_MODE_DRY) begin
			st_d.set.fan = AKR_FAN_AUTO;
		end

		// ***************
		// frame sender
		// ***************
		// a change during a frame is queued so the unit always ends on the latest state
		if (change) begin
			st_d.tx_pend = 1'b1;
		end
		unique case (st_q.tx)
			TX_IDLE: begin
				if (st_q.tx_pend) begin
					st_d.tx = TX_SEND;
					st_d.tx_pend = change;
					st_d.shreg = st_q.set;
					st_d.bit_cnt = 6'(AKR_FRAME_BITS - 1);
					st_d.bit_tmr = 13'(AKR_TX_CYC - 1);
				end
			end
			TX_SEND: begin
				if (st_q.bit_tmr != 13'h0) begin
					st_d.bit_tmr = st_q.bit_tmr - 13'h1;
				end else if (st_q.bit_cnt == 6'h0) begin
					st_d.tx = TX_IDLE;
					// an empty register keeps the idle line low without extra gating
					st_d.shreg = '0;
				end else begin
					st_d.bit_tmr = 13'(AKR_TX_CYC - 1);
					st_d.bit_cnt = st_q.bit_cnt - 6'h1;
					st_d.shreg = {st_q.shreg[AKR_FRAME_BITS-2:0], 1'b0};
				end
			end
		endcase

		// ***************
		// display
		// ***************
		// decoded from the next state so the icons register in step with the settings
		st_d.lcd = '0;
		st_d.lcd.tx_icon = (st_d.tx == TX_SEND);
		st_d.lcd.run_icon = st_d.set.run;
		st_d.lcd.mode = st_d.set.mode;
		unique case (st_d.set.fan)
			AKR_FAN_AUTO: st_d.lcd.fan_bars = 3'h0;
			AKR_FAN_LOW: st_d.lcd.fan_bars = 3'h1;
			AKR_FAN_MED: st_d.lcd.fan_bars = 3'h3;
			AKR_FAN_HIGH: st_d.lcd.fan_bars = 3'h7;
		endcase
		st_d.lcd.temp_show = (st_d.set.mode != AKR_MODE_FAN);
		st_d.lcd.temp = st_d.set.temp;
		if (!st_d.show_clock && (st_d.edit == ED_ON || st_d.set.timer_on != 8'h00)) begin
			st_d.lcd.time_is_timer = 1'b1;
			st_d.lcd.time_min = ten_min(st_d.set.timer_on);
		end else if (!st_d.show_clock &&
			(st_d.edit == ED_OFF || st_d.set.timer_off != 8'h00)) begin
			st_d.lcd.time_is_timer = 1'b1;
			st_d.lcd.time_min = ten_min(st_d.set.timer_off);
		end else begin
			st_d.lcd.time_min = st_d.clock_min;
		end
		st_d.lcd.lock_icon = st_d.lock;
		st_d.lcd.sleep_icon = st_d.set.sleep;
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.set.temp <= AKR_TEMP_RST;
			st_q.clock_min <= AKR_CLOCK_RST;
			// display of the default settings
			st_q.lcd.temp_show <= 1'b1;
			st_q.lcd.temp <= AKR_TEMP_RST;
			st_q.lcd.time_min <= AKR_CLOCK_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ***************
	// outputs
	// ***************
	assign setting_o = st_q.set;
	assign lock_o = st_q.lock;
	assign frame_active_o = (st_q.tx == TX_SEND);
	assign frame_bit_o = st_q.shreg[AKR_FRAME_BITS-1];
	assign lcd_o = st_q.lcd;
endmodule

// ==== bench/akr_remote_properties.sv ====
// checker for the remote key state machine, sees only the top ports
// assumes it is bound to akr_remote from the testbench top file
`timescale 1ns/1ps
module akr_remote_properties
	import akr_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// inputs
	input wire logic cool_only_i,
	input wire logic [AKR_NKEYS-1:0] key_pin_i,
	// outputs
	input wire logic frame_bit_o,
	input wire logic frame_active_o,
	input wire akr_setting_t setting_o,
	input wire akr_lcd_t lcd_o,
	input wire logic lock_o
);
	// ********************
	// properties
	// ********************
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	// a settled change while idle must launch a frame
	sequence s_change;
		$changed(setting_o) && !frame_active_o;
	endsequence
	sequence s_start;
		$rose(frame_active_o);
	endsequence

	a_temp_range: assert property (setting_o.temp >= AKR_TEMP_MIN &&
		setting_o.temp <= AKR_TEMP_MAX)
		else $error("setpoint out of range");
	a_temp_hide: assert property (setting_o.mode == AKR_MODE_FAN |-> !lcd_o.temp_show)
		else $error("setpoint shown in fan mode");
	a_lcd_mirror: assert property (lcd_o.temp == setting_o.temp &&
		lcd_o.mode == setting_o.mode)
		else $error("setpoint or mode display differs from settings");
	a_fan_forced: assert property (setting_o.mode inside {AKR_MODE_AUTO, AKR_MODE_DRY}
		|-> setting_o.fan == AKR_FAN_AUTO)
		else $error("fan not forced to auto");
	a_no_heat: assert property (cool_only_i && $changed(setting_o.mode)
		|-> setting_o.mode != AKR_MODE_HEAT)
		else $error("heat entered on cooling-only model");
	a_tx_icon: assert property (lcd_o.tx_icon == frame_active_o)
		else $error("transmission icon differs from frame activity");
	a_sleep_icon: assert property (lcd_o.sleep_icon == setting_o.sleep)
		else $error("sleep icon differs from sleep state");
	a_run_icon: assert property (lcd_o.run_icon == setting_o.run)
		else $error("run icon differs from run state");
	a_lock_icon: assert property (lcd_o.lock_icon == lock_o)
		else $error("lock icon differs from lock state");
	a_fan_bars: assert property (lcd_o.fan_bars == {
		setting_o.fan == AKR_FAN_HIGH,
		setting_o.fan inside {AKR_FAN_MED, AKR_FAN_HIGH},
		setting_o.fan != AKR_FAN_AUTO})
		else $error("fan bars wrong for speed");
	a_timer_range: assert property (setting_o.timer_on <= AKR_TIMER_MAX &&
		setting_o.timer_off <= AKR_TIMER_MAX)
		else $error("timer beyond 23:50");
	a_lock_hold: assert property ($past(lock_o) && lock_o |-> $stable(setting_o))
		else $error("setting changed while locked");
	a_frame_start: assert property (s_change |=> frame_active_o)
		else $error("no frame after setting change");
	a_frame_hold: assert property (s_start |=>
		(frame_active_o && $stable(frame_bit_o)) [*8])
		else $error("frame bit unstable at start");
endmodule

// ==== bench/akr_ir_rx.sv ====
// indoor unit receiver model: samples each frame bit mid-period
// assumes frame_active_i frames the bits, MSB first
`timescale 1ns/1ps
module akr_ir_rx
	import akr_pkg::*;
(
	// clock
	input wire logic mclk_i,
	// link
	input wire logic frame_active_i,
	input wire logic frame_bit_i,
	// received bits, first bit shifts furthest up
	output logic [39:0] bits_o
);
	int cnt;
	// ********************
	// capture
	// ********************
	always_ff @(posedge mclk_i) begin
		if (!frame_active_i) begin
			cnt <= 0;
			bits_o <= '0;
		end else begin
			cnt <= (cnt == AKR_TX_CYC - 1) ? 0 : cnt + 1;
			if (cnt == AKR_TX_CYC / 2) begin
				bits_o <= {bits_o[38:0], frame_bit_i};
			end
		end
	end
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the remote key state machine
// assumes the receiver model and checker files are compiled first
`timescale 1ns/1ps
module testbench
	import akr_pkg::*;
;
	localparam int k_on = 15, k_mode = 14, k_fan = 13, k_up = 12, k_dn = 11, k_sw = 10;
	localparam int k_dir = 9, k_bst = 8, k_slp = 7, k_rst = 6, k_can = 5, k_tmr = 4;
	localparam int k_clk = 3, k_dsp = 2, k_lck = 1, k_oxy = 0;
	logic mclk_i, reset_n_i, cool_only_i, frame_bit_o, frame_active_o, lock_o;
	logic [AKR_NKEYS-1:0] key_pin_i;
	akr_setting_t setting_o;
	akr_lcd_t lcd_o;
	logic [39:0] rx_bits;
	int err_total, tests_run;

	akr_remote uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cool_only_i(cool_only_i),
		.key_pin_i(key_pin_i), .frame_bit_o(frame_bit_o), .frame_active_o(frame_active_o),
		.setting_o(setting_o), .lcd_o(lcd_o), .lock_o(lock_o));
	akr_ir_rx rx (.mclk_i(mclk_i), .frame_active_i(frame_active_o), .frame_bit_i(frame_bit_o),
		.bits_o(rx_bits));

	// ********************
	// helpers
	// ********************
	task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	// pin high two cycles, then low long enough for the update to land
	task automatic press(input int b);
		@(posedge mclk_i);
		#1 key_pin_i[b] = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1 key_pin_i[b] = 1'b0;
		repeat (4) @(posedge mclk_i);
		#1;
	endtask
	task automatic finish_test();
		$display("tests %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ********************
	// scenarios
	// ********************
	task automatic t_frame();
		chk("temp", AKR_TEMP_RST, setting_o.temp);
		chk("clock", AKR_CLOCK_RST, lcd_o.time_min);
		press(k_on);
		chk("run", 1, setting_o.run);
		chk("tx", 1, lcd_o.tx_icon);
		repeat (16100) @(posedge mclk_i);
		chk("bits", 4'b1000, rx_bits[3:0]);
		$display("frame done");
	endtask
	task automatic t_modes();
		akr_mode_t full[5] = '{AKR_MODE_COOL, AKR_MODE_DRY, AKR_MODE_HEAT,
			AKR_MODE_FAN, AKR_MODE_AUTO};
		akr_mode_t cold[4] = '{AKR_MODE_COOL, AKR_MODE_DRY, AKR_MODE_FAN, AKR_MODE_AUTO};
		for (int i = 0; i < 5; i++) begin
			press(k_mode);
			chk("mode", full[i], setting_o.mode);
		end
		cool_only_i = 1'b1;
		for (int i = 0; i < 4; i++) begin
			press(k_mode);
			chk("mode_c", cold[i], setting_o.mode);
		end
		cool_only_i = 1'b0;
		$display("modes done");
	endtask
	task automatic t_toggles();
		for (int i = 0; i < 2; i++) begin
			press(k_on);
			chk("run", i, setting_o.run);
			press(k_sw);
			chk("swing", i == 0, setting_o.swing);
			press(k_dsp);
			chk("disp", i == 0, setting_o.disp_toggle);
			press(k_oxy);
			chk("oxy", i == 0, setting_o.oxygen);
		end
		$display("toggles done");
	endtask
	task automatic t_fan();
		logic [2:0] bars[4] = '{3'h1, 3'h3, 3'h7, 3'h0};
		press(k_mode);
		for (int i = 0; i < 4; i++) begin
			press(k_fan);
			chk("fan", (i + 1) % 4, setting_o.fan);
			chk("bars", bars[i], lcd_o.fan_bars);
		end
		press(k_fan);
		press(k_mode);
		chk("fan_dry", AKR_FAN_AUTO, setting_o.fan);
		$display("fan done");
	endtask
	task automatic t_sleep();
		press(k_mode);
		press(k_slp);
		chk("icon", 1, lcd_o.sleep_icon);
		press(k_slp);
		chk("icon", 0, lcd_o.sleep_icon);
		press(k_mode);
		press(k_slp);
		chk("slp_fan", 0, setting_o.sleep);
		chk("tshow", 0, lcd_o.temp_show);
		press(k_mode);
		press(k_mode);
		press(k_bst);
		chk("boost", 1, setting_o.boost);
		press(k_bst);
		chk("boost", 0, setting_o.boost);
		press(k_slp);
		press(k_up);
		chk("slp_up", 0, setting_o.sleep);
		$display("sleep done");
	endtask
	task automatic t_temp();
		repeat (6) press(k_up);
		chk("tmax", AKR_TEMP_MAX, setting_o.temp);
		repeat (14) press(k_dn);
		chk("tmin", AKR_TEMP_MIN, setting_o.temp);
		for (int i = 1; i <= 16; i++) begin
			press(k_dir);
			chk("angle", (i <= 15) ? i : 30 - i, setting_o.angle);
		end
		$display("temp done");
	endtask
	task automatic t_timer();
		press(k_tmr);
		press(k_dn);
		chk("ton", AKR_TIMER_MAX, setting_o.timer_on);
		chk("tfield", 1, lcd_o.time_is_timer);
		press(k_up);
		press(k_up);
		chk("ton", 1, setting_o.timer_on);
		press(k_can);
		chk("both", 0, {setting_o.timer_on, setting_o.timer_off});
		press(k_clk);
		chk("clock", AKR_CLOCK_RST, lcd_o.time_min);
		$display("timer done");
	endtask
	task automatic t_lock();
		press(k_lck);
		chk("lock", 1, lock_o);
		press(k_up);
		chk("tlock", AKR_TEMP_MIN, setting_o.temp);
		press(k_lck);
		press(k_rst);
		chk("dflt", {1'b0, AKR_MODE_AUTO, AKR_TEMP_RST, AKR_ANGLE_RST},
			{setting_o.run, setting_o.mode, setting_o.temp, setting_o.angle});
		$display("lock done");
	endtask

	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	// whole run is near 17000 cycles
	initial begin
		#200000;
		err_total++;
		finish_test();
	end
	initial begin
		err_total = 0;
		tests_run = 0;
		reset_n_i = 1'b0;
		cool_only_i = 1'b0;
		key_pin_i = '0;
		repeat (5) @(posedge mclk_i);
		#1 reset_n_i = 1'b1;
		repeat (4) @(posedge mclk_i);
		t_frame();
		t_modes();
		t_toggles();
		t_fan();
		t_sleep();
		t_temp();
		t_timer();
		t_lock();
		finish_test();
	end
endmodule

bind akr_remote akr_remote_properties chk_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
	.cool_only_i(cool_only_i), .key_pin_i(key_pin_i), .frame_bit_o(frame_bit_o),
	.frame_active_o(frame_active_o), .setting_o(setting_o), .lcd_o(lcd_o), .lock_o(lock_o));
